// ---- src/mem_map_pkg.sv ----
// Package: address map, widths and timing constants of the on-chip memory decoder.
// Assumes a 32-bit byte-addressed core request port and a 100 MHz core clock.
package mem_map_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [31:0] ZERO_BASE = 32'h0000_0000;
  localparam logic [31:0] SRAM_BASE = 32'h0001_0000;
  localparam logic [31:0] FLASH_BASE = 32'h0008_0000;
  localparam logic [31:0] PERIPH_BASE = 32'hFFFE_0000;
  localparam logic [31:0] AHB_BASE = 32'hFFFF_F000;
  localparam logic [31:0] MIRROR_SIZE = 32'h0001_0000;
  localparam logic [31:0] FLASH_SIZE = 32'h0001_0000;
  localparam logic [31:0] SRAM_SIZE = 32'h0000_2000;
  localparam logic [31:0] BOOT_SIZE = 32'h0000_0800;
  localparam logic [31:0] PAGE_SIZE = 32'h0000_0200;

  // Fast-bus windows: flash control, GPIO, PWM
  localparam logic [31:0] FLASH_CTL_BASE = 32'hFFFF_F800;
  localparam logic [31:0] FLASH_CTL_SIZE = 32'h0000_0100;
  localparam logic [31:0] GPIO_BASE = 32'hFFFF_F400;
  localparam logic [31:0] GPIO_SIZE = 32'h0000_0100;
  localparam logic [31:0] PWM_BASE = 32'hFFFF_FC00;
  localparam logic [31:0] PWM_SIZE = 32'h0000_0100;

  // Remap control register, bit position of the flash-at-zero select
  localparam logic [31:0] REMAP_ADDR = 32'hFFFF_0220;
  localparam int REMAP_BIT = 0;

  // ----------------------------------------------------------------
  // Access sizes and timing
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} acc_size_t;
  localparam int AHB_CYCLES = 1;
  localparam int APB_CYCLES = 2;
  localparam int CORE_PERIOD_NS = 10;
  localparam int FLASH_HALF_NS = 24;
  // Each flash halfword read needs this many core cycles (rounded up)
  localparam int FLASH_HALF_CYCLES = (FLASH_HALF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

  // Target selection
  typedef enum logic [2:0] {TGT_NONE, TGT_FLASH, TGT_SRAM, TGT_AHB, TGT_APB} target_t;

endpackage : mem_map_pkg

// ---- src/lane_steer.sv ----
// Little-endian byte lane steering between the core and a 32-bit array.
// Assumes the caller gives the low address bits and the access size.
`timescale 1ns/1ns
module lane_steer
  import mem_map_pkg::*;
(
  input wire logic [1:0] addr_lo,
  input wire mem_map_pkg::acc_size_t size,
  input wire logic [31:0] wdata_core,
  input wire logic [31:0] rdata_word,
  output logic [31:0] wdata_lane,
  output logic [3:0] byte_en,
  output logic [31:0] rdata_core
);

  // ----------------------------------------------------------------
  // Write placement and read extraction
  // ----------------------------------------------------------------
  // Lowest address holds the least significant byte
  always_comb
  begin
    case (size)
      SZ_BYTE:
      begin
        byte_en = 4'h1 << addr_lo;
        wdata_lane = {4{wdata_core[7:0]}};
        rdata_core = {24'h000000, rdata_word[{addr_lo, 3'h0} +: 8]};
      end
      SZ_HALF:
      begin
        byte_en = addr_lo[1] ? 4'hC : 4'h3;
        wdata_lane = {2{wdata_core[15:0]}};
        rdata_core = {16'h0000, rdata_word[{addr_lo[1], 4'h0} +: 16]};
      end
      default:
      begin
        byte_en = 4'hF;
        wdata_lane = wdata_core;
        rdata_core = rdata_word;
      end
    endcase
  end

endmodule : lane_steer

// ---- src/mem_map_decoder.sv ----
// On-chip memory map decoder: flash, SRAM, hidden boot page, register buses.
// Assumes one core request at a time, held until done; flash and SRAM
// storage live here as flip-flop arrays sized by parameters.
//
// How it works
// - Reset maps flash at address zero.
// - Clearing remap bit maps SRAM at zero.
// - One flat 32-bit byte address space.
// - Little-endian byte order everywhere.
// - Flash 16-bit halfwords, 512-byte pages, 2 kB kernel.
// - Word fetch from flash takes two halfword reads.
// - Halves of a flash word read paced to rated speed; byte and halfword reads finish in one cycle.
// - SRAM is 32 bits wide, single access.
// - Boot page hidden from user code.
// - Registers decoded in top 128 kB, from PERIPH_BASE up.
// - Fast bus one cycle, peripheral bus two.
// - Flash, GPIO, PWM on fast bus; rest peripheral.
// - Flash erased by pages before byte programming.
`timescale 1ns/1ns
module mem_map_decoder
  import mem_map_pkg::*;
#(
  parameter int FLASH_HALFWORDS = 32768,
  parameter int SRAM_WORDS = 2048
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic req,
  input wire logic [31:0] addr,
  input wire logic write,
  input wire mem_map_pkg::acc_size_t size,
  input wire logic [31:0] wdata,
  input wire logic kernel_mode,
  input wire logic flash_erase,
  input wire logic [31:0] periph_rdata,
  output logic done_ff,
  output logic [31:0] rdata_ff,
  output logic fault_ff,
  output logic periph_sel_ff,
  output logic periph_fast_ff,
  output logic periph_write_ff,
  output logic [31:0] periph_addr_ff,
  output logic [31:0] periph_wdata_ff,
  output logic remap_flash_ff
);

  localparam int FA_W = $clog2(FLASH_HALFWORDS);
  localparam int SA_W = $clog2(SRAM_WORDS);
  localparam int PG_HW = PAGE_SIZE / 2;

  typedef enum {ST_IDLE, ST_FLASH_LO, ST_FLASH_HI, ST_APB_WAIT, ST_DONE} state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic in_win(logic [31:0] a, logic [31:0] base, logic [31:0] span);
    in_win = (a >= base) && ((a - base) < span);
  endfunction : in_win

  // Flash offset of an address; zero region folds onto flash when mirrored
  function automatic logic [31:0] flash_off(logic [31:0] a);
    flash_off = in_win(a, FLASH_BASE, FLASH_SIZE) ? (a - FLASH_BASE) : a;
  endfunction : flash_off

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0] flash_mem [FLASH_HALFWORDS];
  logic [31:0] sram_mem [SRAM_WORDS];

  state_t state_ff;
  target_t tgt;
  logic [31:0] off;
  logic [31:0] word_ff;
  logic [FA_W-1:0] fidx_ff;
  logic [1:0] wait_ff;
  logic [3:0] ben;
  logic [31:0] wlane;
  logic [31:0] rsteer;
  logic [31:0] raw_word;
  logic boot_hit;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Whole 32-bit space decoded; anything unclaimed faults
  always_comb
  begin
    tgt = TGT_NONE;
    off = 32'h0000_0000;
    if (in_win(addr, ZERO_BASE, MIRROR_SIZE))
    begin
      tgt = remap_flash_ff ? TGT_FLASH : TGT_SRAM;
      off = addr;
    end
    else if (in_win(addr, FLASH_BASE, FLASH_SIZE))
    begin
      tgt = TGT_FLASH;
      off = flash_off(addr);
    end
    else if (in_win(addr, SRAM_BASE, SRAM_SIZE))
    begin
      tgt = TGT_SRAM;
      off = addr - SRAM_BASE;
    end
    else if (addr >= PERIPH_BASE)
    begin
      off = addr;
      if (in_win(addr, FLASH_CTL_BASE, FLASH_CTL_SIZE) || in_win(addr, GPIO_BASE, GPIO_SIZE)
          || in_win(addr, PWM_BASE, PWM_SIZE))
        tgt = TGT_AHB;
      else
        tgt = TGT_APB;
    end
    if (tgt == TGT_SRAM && off >= SRAM_SIZE)
      tgt = TGT_NONE;
  end

  // Kernel page is the top 2 kB of flash; user code sees a fault
  assign boot_hit = (tgt == TGT_FLASH) && (off >= (FLASH_SIZE - BOOT_SIZE))
                    && !kernel_mode;

  // Word view of the flash pair or the SRAM word, for lane steering
  assign raw_word = (tgt == TGT_SRAM) ? sram_mem[off[SA_W+1:2]]
                    : {flash_mem[{off[FA_W:2], 1'b1}], flash_mem[{off[FA_W:2], 1'b0}]};

  lane_steer u_lane (
    .addr_lo(off[1:0]),
    .size(size),
    .wdata_core(wdata),
    .rdata_word(raw_word),
    .wdata_lane(wlane),
    .byte_en(ben),
    .rdata_core(rsteer)
  );

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  // One request in flight; flash word reads split in two halves
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state_ff <= ST_IDLE;
      done_ff <= 1'b0;
      fault_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      word_ff <= 32'h0000_0000;
      fidx_ff <= '0;
      wait_ff <= 2'h0;
      periph_sel_ff <= 1'b0;
      periph_fast_ff <= 1'b0;
      periph_write_ff <= 1'b0;
      periph_addr_ff <= 32'h0000_0000;
      periph_wdata_ff <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      done_ff <= 1'b0;
      fault_ff <= 1'b0;
      case (state_ff)
        ST_IDLE:
        begin
          if (req)
          begin
            if (tgt == TGT_NONE || boot_hit)
            begin
              done_ff <= 1'b1;
              fault_ff <= 1'b1;
              rdata_ff <= 32'h0000_0000;
              state_ff <= ST_DONE;
            end
            else if (tgt == TGT_SRAM)
            begin
              done_ff <= 1'b1;
              rdata_ff <= write ? 32'h0000_0000 : rsteer;
              state_ff <= ST_DONE;
            end
            else if (tgt == TGT_FLASH)
            begin
              fidx_ff <= off[FA_W:1];
              wait_ff <= 2'(FLASH_HALF_CYCLES - 1);
              if (write || size != SZ_WORD)
              begin
                done_ff <= 1'b1;
                rdata_ff <= write ? 32'h0000_0000 : rsteer;
                state_ff <= ST_DONE;
              end
              else
              begin
                fidx_ff <= {off[FA_W:2], 1'b0};
                state_ff <= ST_FLASH_LO;
              end
            end
            else
            begin
              periph_sel_ff <= 1'b1;
              periph_fast_ff <= (tgt == TGT_AHB);
              periph_write_ff <= write;
              periph_addr_ff <= addr;
              periph_wdata_ff <= wdata;
              wait_ff <= 2'((tgt == TGT_AHB ? AHB_CYCLES : APB_CYCLES) - 1);
              state_ff <= ST_APB_WAIT;
            end
          end
        end
        ST_FLASH_LO:
        begin
          if (wait_ff != 2'h0)
            wait_ff <= wait_ff - 2'h1;
          else
          begin
            word_ff[15:0] <= flash_mem[fidx_ff];
            fidx_ff <= fidx_ff + 1'b1;
            wait_ff <= 2'(FLASH_HALF_CYCLES - 1);
            state_ff <= ST_FLASH_HI;
          end
        end
        ST_FLASH_HI:
        begin
          if (wait_ff != 2'h0)
            wait_ff <= wait_ff - 2'h1;
          else
          begin
            rdata_ff <= {flash_mem[fidx_ff], word_ff[15:0]};
            done_ff <= 1'b1;
            state_ff <= ST_DONE;
          end
        end
        ST_APB_WAIT:
        begin
          if (wait_ff != 2'h0)
            wait_ff <= wait_ff - 2'h1;
          else
          begin
            periph_sel_ff <= 1'b0;
            rdata_ff <= periph_write_ff ? 32'h0000_0000 : periph_rdata;
            done_ff <= 1'b1;
            state_ff <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          // Core drops req after done; wait so one request is served once
          if (!req)
            state_ff <= ST_IDLE;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Remap control register (lives on the peripheral bus)
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      remap_flash_ff <= 1'b1;
    else if (clk_en && state_ff == ST_IDLE && req && write && addr == REMAP_ADDR)
      remap_flash_ff <= wdata[REMAP_BIT];
  end

  // ----------------------------------------------------------------
  // SRAM writes
  // ----------------------------------------------------------------
  // Byte enables keep untouched lanes intact
  always_ff @(posedge sys_clk)
  begin
    if (clk_en && state_ff == ST_IDLE && req && write && tgt == TGT_SRAM)
    begin
      for (int b = 0; b < 4; b++)
        if (ben[b])
          sram_mem[off[SA_W+1:2]][b*8 +: 8] <= wlane[b*8 +: 8];
    end
  end

  // ----------------------------------------------------------------
  // Flash storage: page erase to all ones, program clears bits only
  // ----------------------------------------------------------------
  // Programming can only pull bits low, so an unerased page keeps old zeros
  always_ff @(posedge sys_clk)
  begin
    if (clk_en && flash_erase && !req)
    begin
      for (int i = 0; i < PG_HW; i++)
        flash_mem[{addr[FA_W:9], 8'(i)}] <= 16'hFFFF;
    end
    else if (clk_en && state_ff == ST_IDLE && req && write && tgt == TGT_FLASH && !boot_hit)
    begin
      // Lane b lands in halfword b[1] of the pair, so word writes fill both halves
      for (int b = 0; b < 4; b++)
        if (ben[b])
          flash_mem[{off[FA_W:2], b[1]}][b[0]*8 +: 8] <=
            flash_mem[{off[FA_W:2], b[1]}][b[0]*8 +: 8] & wlane[b*8 +: 8];
    end
  end

endmodule : mem_map_decoder

// ---- testbench/mem_map_assertions.sv ----
// Checker: timing and routing properties of the memory map decoder.
// Assumes it is bound to the decoder top and sees only its ports.
`timescale 1ns/1ns
module mem_map_assertions
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic req,
  input wire logic [31:0] addr,
  input wire logic write,
  input wire mem_map_pkg::acc_size_t size,
  input wire logic kernel_mode,
  input wire logic done_ff,
  input wire logic [31:0] rdata_ff,
  input wire logic fault_ff,
  input wire logic periph_sel_ff,
  input wire logic periph_fast_ff,
  input wire logic [31:0] periph_addr_ff,
  input wire logic remap_flash_ff
);
  import mem_map_pkg::*;
  // ----------------------------------------
  // Request classes
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // New request seen at a take edge; the bench always idles between them
  sequence flash_rd_s;
    $rose(req) && clk_en && !write && size == SZ_WORD && addr >= FLASH_BASE
      && addr < FLASH_BASE + FLASH_SIZE - BOOT_SIZE;
  endsequence
  sequence sram_s;
    $rose(req) && clk_en && addr >= SRAM_BASE && addr < SRAM_BASE + SRAM_SIZE;
  endsequence
  sequence boot_s;
    $rose(req) && clk_en && !kernel_mode && addr >= FLASH_BASE + FLASH_SIZE - BOOT_SIZE
      && addr < FLASH_BASE + FLASH_SIZE;
  endsequence
  sequence slow_sel_s;
    $rose(periph_sel_ff) && !periph_fast_ff;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  reset_remap_a: assert property (disable iff (1'b0) !reset_n && clk_en |=> remap_flash_ff)
    else $error("remap select not set by reset");
  fault_done_a: assert property (fault_ff |-> done_ff && rdata_ff == 32'h0)
    else $error("fault without completion or with data");
  done_pulse_a: assert property (done_ff && clk_en |=> !done_ff)
    else $error("completion longer than one cycle");
  flash_word_a: assert property (flash_rd_s |=> !done_ff [*6] ##1 done_ff)
    else $error("flash word read not paced as two halfwords");
  sram_single_a: assert property (sram_s |=> done_ff && !fault_ff)
    else $error("SRAM access not single cycle");
  boot_hidden_a: assert property (boot_s |=> done_ff && fault_ff)
    else $error("boot page reachable from user code");
  fast_bus_a: assert property ($rose(periph_sel_ff) && periph_fast_ff |=> !periph_sel_ff && done_ff)
    else $error("fast bus access not one cycle");
  slow_bus_a: assert property (slow_sel_s |=> periph_sel_ff && !done_ff ##1 done_ff)
    else $error("peripheral bus access not two cycles");
  bus_route_a: assert property (periph_sel_ff |-> periph_fast_ff == (periph_addr_ff[31:8] ==
    GPIO_BASE[31:8] || periph_addr_ff[31:8] == PWM_BASE[31:8] || periph_addr_ff[31:8] == FLASH_CTL_BASE[31:8]))
    else $error("register access on wrong bus");
  reg_region_a: assert property (periph_sel_ff |-> periph_addr_ff >= PERIPH_BASE)
    else $error("register access outside top pages");
endmodule : mem_map_assertions

bind mem_map_decoder mem_map_assertions u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
  .clk_en(clk_en), .req(req), .addr(addr), .write(write), .size(size), .kernel_mode(kernel_mode),
  .done_ff(done_ff), .rdata_ff(rdata_ff), .fault_ff(fault_ff), .periph_sel_ff(periph_sel_ff),
  .periph_fast_ff(periph_fast_ff), .periph_addr_ff(periph_addr_ff),
  .remap_flash_ff(remap_flash_ff));

// ---- testbench/periph_bus_model.sv ----
// Partner: register bus responder on the far side of the decoder.
// Assumes read data is sampled only while the select is high.
`timescale 1ns/1ns
module periph_bus_model
(
  input wire logic sys_clk,
  input wire logic periph_sel_ff,
  input wire logic [31:0] periph_addr_ff,
  output logic [31:0] periph_rdata
);
  logic [31:0] last_ff = 32'h0;
  // Address-derived answer; released bus flips so stale data never matches
  assign periph_rdata = periph_sel_ff ? (periph_addr_ff ^ 32'h5A5A_A5A5) : ~last_ff;
  // Track the last driven value
  always_ff @(posedge sys_clk)
  begin
    last_ff <= periph_rdata;
  end
endmodule : periph_bus_model

// ---- testbench/tb_onchip_memory_map_decoder.sv ----
// Testbench: self-checking run of the memory map decoder.
// Assumes the decoder package, the checker bind and the bus model.
`timescale 1ns/1ns
module tb_onchip_memory_map_decoder;
  import mem_map_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic req = 1'b0;
  logic [31:0] addr = 32'h0;
  logic write = 1'b0;
  acc_size_t size = SZ_WORD;
  logic [31:0] wdata = 32'h0;
  logic kernel_mode = 1'b0;
  logic flash_erase = 1'b0;
  logic [31:0] periph_rdata, rdata_ff, periph_addr_ff, periph_wdata_ff, w, v, a, fw;
  logic done_ff, fault_ff, periph_sel_ff, periph_fast_ff, periph_write_ff, remap_flash_ff;
  logic seen_fast;
  logic [1:0] lo;
  logic [31:0] bus_a [4] = '{GPIO_BASE + 32'h4, PWM_BASE, FLASH_CTL_BASE + 32'h8, 32'hFFFF_0300};
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  mem_map_decoder DUT (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .req(req),
    .addr(addr), .write(write), .size(size), .wdata(wdata), .kernel_mode(kernel_mode),
    .flash_erase(flash_erase), .periph_rdata(periph_rdata), .done_ff(done_ff),
    .rdata_ff(rdata_ff), .fault_ff(fault_ff), .periph_sel_ff(periph_sel_ff),
    .periph_fast_ff(periph_fast_ff), .periph_write_ff(periph_write_ff),
    .periph_addr_ff(periph_addr_ff), .periph_wdata_ff(periph_wdata_ff),
    .remap_flash_ff(remap_flash_ff));
  periph_bus_model u_bus (.sys_clk(sys_clk), .periph_sel_ff(periph_sel_ff),
    .periph_addr_ff(periph_addr_ff), .periph_rdata(periph_rdata));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lane(input logic [31:0] wd, input logic [1:0] l,
    input acc_size_t s);
    logic [31:0] sh;
    sh = wd >> (8 * l);
    return s == SZ_BYTE ? {24'h0, sh[7:0]} : s == SZ_HALF ? {16'h0, sh[15:0]} : wd;
  endfunction : lane
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  // One page erase, request low so it cannot clash with an access
  task automatic erase(input logic [31:0] ad);
    @(posedge sys_clk);
    addr <= ad;
    flash_erase <= 1'b1;
    @(posedge sys_clk);
    flash_erase <= 1'b0;
  endtask : erase
  // One whole access: cycles to completion, fault flag and read data
  task automatic acc(input logic [31:0] ad, input logic wr, input acc_size_t s,
    input logic [31:0] d, input int cyc, input logic f, input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= 1'b1;
    addr <= ad;
    write <= wr;
    size <= s;
    wdata <= d;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
      if (periph_sel_ff === 1'b1)
        seen_fast = periph_fast_ff;
    end
    while (done_ff !== 1'b1 && n < 20);
    chk(32'(n), 32'(cyc));
    chk({31'h0, fault_ff}, {31'h0, f});
    chk(rdata_ff, exp);
    @(posedge sys_clk);
    req <= 1'b0;
    @(posedge sys_clk);
  endtask : acc
  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  // Cut a hang short well past the expected run length
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      complete_run();
    end
  end
  initial
  begin
    void'($urandom(35838));
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk({31'h0, remap_flash_ff}, 32'h1);
    // Erase a page, then program, mirror and lane reads
    erase(FLASH_BASE);
    w = $urandom;
    v = $urandom;
    acc(FLASH_BASE, 1'b0, SZ_WORD, 32'h0, 7, 1'b0, 32'hFFFF_FFFF);
    acc(FLASH_BASE, 1'b1, SZ_WORD, w, 1, 1'b0, 32'h0);
    acc(FLASH_BASE, 1'b0, SZ_WORD, 32'h0, 7, 1'b0, w);
    acc(ZERO_BASE, 1'b0, SZ_WORD, 32'h0, 7, 1'b0, w);
    acc(FLASH_BASE + 32'h1, 1'b0, SZ_BYTE, 32'h0, 1, 1'b0, lane(w, 2'd1, SZ_BYTE));
    acc(FLASH_BASE + 32'h2, 1'b0, SZ_HALF, 32'h0, 1, 1'b0, lane(w, 2'd2, SZ_HALF));
    acc(FLASH_BASE, 1'b1, SZ_WORD, v, 1, 1'b0, 32'h0);
    acc(FLASH_BASE, 1'b0, SZ_WORD, 32'h0, 7, 1'b0, w & v);
    fw = w & v;
    // Refused places: hidden boot page, unmapped, past the SRAM end
    acc(FLASH_BASE + FLASH_SIZE - BOOT_SIZE, 1'b0, SZ_WORD, 32'h0, 1, 1'b1, 32'h0);
    acc(FLASH_BASE + FLASH_SIZE - 32'h4, 1'b1, SZ_WORD, w, 1, 1'b1, 32'h0);
    acc(32'h0010_0000, 1'b0, SZ_WORD, 32'h0, 1, 1'b1, 32'h0);
    acc(SRAM_BASE + SRAM_SIZE, 1'b0, SZ_WORD, 32'h0, 1, 1'b1, 32'h0);
    // Kernel code still reaches the boot page
    erase(FLASH_BASE + FLASH_SIZE - BOOT_SIZE);
    kernel_mode <= 1'b1;
    acc(FLASH_BASE + FLASH_SIZE - BOOT_SIZE, 1'b1, SZ_WORD, w, 1, 1'b0, 32'h0);
    acc(FLASH_BASE + FLASH_SIZE - BOOT_SIZE, 1'b0, SZ_WORD, 32'h0, 7, 1'b0, w);
    kernel_mode <= 1'b0;
    // SRAM words with byte merges, last word of the array first
    for (int i = 0; i < 4; i++)
    begin
      a = i == 0 ? SRAM_BASE + SRAM_SIZE - 32'h4
                 : SRAM_BASE + 32'({$urandom_range(0, 2047), 2'b00});
      w = $urandom;
      v = {24'h0, 8'($urandom)};
      lo = 2'($urandom);
      acc(a, 1'b1, SZ_WORD, w, 1, 1'b0, 32'h0);
      acc(a + lo, 1'b1, SZ_BYTE, v, 1, 1'b0, 32'h0);
      w = (w & ~(32'hFF << (8 * lo))) | (v << (8 * lo));
      acc(a, 1'b0, SZ_WORD, 32'h0, 1, 1'b0, w);
      acc(a + lo, 1'b0, SZ_BYTE, 32'h0, 1, 1'b0, lane(w, lo, SZ_BYTE));
      acc(a + {lo[1], 1'b0}, 1'b0, SZ_HALF, 32'h0, 1, 1'b0, lane(w, {lo[1], 1'b0}, SZ_HALF));
    end
    // Register buses: three fast windows and one peripheral address
    for (int i = 0; i < 4; i++)
    begin
      acc(bus_a[i], 1'b0, SZ_WORD, 32'h0, i < 3 ? 2 : 3, 1'b0, bus_a[i] ^ 32'h5A5A_A5A5);
      chk({31'h0, seen_fast}, {31'h0, i < 3});
    end
    // Remap SRAM to zero
    acc(REMAP_ADDR, 1'b1, SZ_WORD, 32'h0, 3, 1'b0, 32'h0);
    chk({31'h0, remap_flash_ff}, 32'h0);
    acc(SRAM_BASE, 1'b1, SZ_WORD, w, 1, 1'b0, 32'h0);
    acc(ZERO_BASE, 1'b0, SZ_WORD, 32'h0, 1, 1'b0, w);
    // Held request under a frozen enable: nothing moves until it returns
    @(posedge sys_clk);
    clk_en <= 1'b0;
    req <= 1'b1;
    addr <= SRAM_BASE;
    write <= 1'b0;
    size <= SZ_WORD;
    repeat (3) @(posedge sys_clk);
    clk_en <= 1'b1;
    #1;
    chk({31'h0, done_ff}, 32'h0);
    @(posedge sys_clk);
    #1;
    chk({31'h0, done_ff}, 32'h1);
    chk(rdata_ff, w);
    @(posedge sys_clk);
    req <= 1'b0;
    @(posedge sys_clk);
    // Reset in mid-run puts flash back at zero
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk({31'h0, remap_flash_ff}, 32'h1);
    acc(ZERO_BASE, 1'b0, SZ_WORD, 32'h0, 7, 1'b0, fw);
    complete_run();
  end
endmodule : tb_onchip_memory_map_decoder
